// *** wsm_pkg.sv ***
// wsm_pkg: opcodes, function codes and field positions for the wide
// shift, multiply and system-control move datapath.
// assumes a 32-bit instruction word with a 6-bit major opcode on top.
package wsm_pkg;
    localparam int XLEN = 64;
    localparam int OP_HI = 31;
    localparam int OP_LO = 26;
    localparam int SUB_HI = 25;
    localparam int SUB_LO = 21;
    localparam int RS_HI = 25;
    localparam int RS_LO = 21;
    localparam int RT_HI = 20;
    localparam int RT_LO = 16;
    localparam int RD_HI = 15;
    localparam int RD_LO = 11;
    localparam int SA_HI = 10;
    localparam int SA_LO = 6;
    localparam int FN_HI = 5;
    localparam int FN_LO = 0;
    localparam logic [5:0] OP_REGCLASS = 6'h00;
    localparam logic [5:0] OP_SYSCTL = 6'h10;
    localparam logic [4:0] SUB_MFW = 5'h01;
    localparam logic [4:0] SUB_MTW = 5'h05;
    localparam logic [5:0] FN_SLLV = 6'h14;
    localparam logic [5:0] FN_SRLV = 6'h16;
    localparam logic [5:0] FN_SRAV = 6'h17;
    localparam logic [5:0] FN_SMUL = 6'h1C;
    localparam logic [5:0] FN_UMUL = 6'h1D;
    localparam logic [5:0] FN_SLL = 6'h38;
    localparam logic [5:0] FN_SRL = 6'h3A;
    localparam logic [5:0] FN_SRA = 6'h3B;
    localparam logic [5:0] FN_SLL32 = 6'h3C;
    localparam logic [5:0] FN_SRA32 = 6'h3F;
    localparam logic [63:0] WORD_RST = 64'h0000000000000000;
    localparam logic [4:0] IDX_RST = 5'h00;
    typedef enum logic [1:0] {
        WSM_IDLE = 2'b00,
        WSM_MOVE = 2'b01
    } wsm_state_t;
endpackage : wsm_pkg

// *** wsm_datapath.sv ***
// wsm_datapath: wide shift, wide multiply and wide system-control moves.
// assumes decode presents one instruction per valid pulse with operands
// already read from the register file; results are registered once, move-to twice.
`timescale 1ns/1ps
module wsm_datapath import wsm_pkg::*; #(
    parameter int WIDTH = 64
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // instruction from decode
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [63:0] source_a_data,
    input wire logic [63:0] source_b_data,
    // processor mode
    input wire logic mode_64bit,
    input wire logic mode_kernel,
    input wire logic sysctl_enabled,
    // system-control register file read port
    input wire logic [63:0] sysctl_rd_data,
    // general register write
    output logic gpr_we_ff,
    output logic [4:0] gpr_idx_ff,
    output logic [63:0] gpr_data_ff,
    // product registers
    output logic prod_we_ff,
    output logic [63:0] product_bottom_reg_ff,
    output logic [63:0] product_upper_reg_ff,
    // system-control write
    output logic sysctl_we_ff,
    output logic [4:0] sysctl_idx_ff,
    output logic [63:0] sysctl_data_ff,
    // exceptions
    output logic rsvd_exc_ff,
    output logic unusable_exc_ff,
    output logic ovf_exc_ff
);
    // refused at elaboration: shifter and product split assume 64 bits
    if (WIDTH != XLEN) begin : g_width_check
        $error("wsm_datapath supports only 64-bit width");
    end

    function automatic logic [63:0] wide_shift(input logic [63:0] val,
            input logic [5:0] amt, input logic right, input logic arith);
        logic [127:0] ext;
        ext = 128'h0;
        if (!right) begin
            wide_shift = val << amt;
        end else begin
            ext = {{64{arith & val[63]}}, val};
            ext = ext >> amt;
            wide_shift = ext[63:0];
        end
    endfunction : wide_shift

    logic [5:0] opc;
    logic [4:0] sub;
    logic [5:0] fn;
    logic [4:0] cnt;
    logic [4:0] rt_i;
    logic [4:0] rd_i;
    logic [5:0] var_amt;
    logic [5:0] imm_amt;
    logic [5:0] plus_amt;
    logic is_move_from;
    logic is_move_to;
    logic is_shift;
    logic is_mul;
    logic grp;
    logic mode_ok;
    logic cop_ok;
    logic [63:0] shift_res;
    logic [5:0] sh_amt;
    logic sh_right;
    logic sh_arith;
    logic [127:0] prod;
    logic go;

    assign opc = instr_word[OP_HI:OP_LO];
    assign sub = instr_word[SUB_HI:SUB_LO];
    assign fn = instr_word[FN_HI:FN_LO];
    assign cnt = instr_word[SA_HI:SA_LO];
    assign rt_i = instr_word[RT_HI:RT_LO];
    assign rd_i = instr_word[RD_HI:RD_LO];
    assign var_amt = source_a_data[5:0];
    assign imm_amt = {1'b0, cnt};
    assign plus_amt = {1'b1, cnt};
    assign is_move_from = (opc == OP_SYSCTL) && (sub == SUB_MFW);
    assign is_move_to = (opc == OP_SYSCTL) && (sub == SUB_MTW);
    assign is_mul = (opc == OP_REGCLASS) &&
        ((fn == FN_SMUL) || (fn == FN_UMUL));
    assign is_shift = (opc == OP_REGCLASS) && ((fn == FN_SLLV) ||
        (fn == FN_SRLV) || (fn == FN_SRAV) || (fn == FN_SLL) ||
        (fn == FN_SRL) || (fn == FN_SRA) || (fn == FN_SLL32) ||
        (fn == FN_SRA32));
    assign grp = is_move_from || is_move_to || is_mul || is_shift;
    assign mode_ok = mode_64bit || mode_kernel;
    // kernel always reaches the unit; others need it enabled
    assign cop_ok = mode_kernel || sysctl_enabled;
    assign go = clk_en && instr_valid && grp && mode_ok;

    // one shifter serves every form; only amount, direction and fill differ
    always_comb begin
        sh_amt = imm_amt;
        sh_right = 1'b0;
        sh_arith = 1'b0;
        case (fn)
            FN_SLLV: sh_amt = var_amt;
            FN_SRLV: begin
                sh_amt = var_amt;
                sh_right = 1'b1;
            end
            FN_SRAV: begin
                sh_amt = var_amt;
                sh_right = 1'b1;
                sh_arith = 1'b1;
            end
            FN_SRL: sh_right = 1'b1;
            FN_SRA: begin
                sh_right = 1'b1;
                sh_arith = 1'b1;
            end
            FN_SLL32: sh_amt = plus_amt;
            FN_SRA32: begin
                sh_amt = plus_amt;
                sh_right = 1'b1;
                sh_arith = 1'b1;
            end
            default: sh_amt = imm_amt;
        endcase
        shift_res = wide_shift(source_b_data, sh_amt, sh_right, sh_arith);
    end

    // signed uses sign extension, unsigned zero extension
    always_comb begin
        if (fn == FN_SMUL) begin
            prod = 128'($signed({{64{source_a_data[63]}}, source_a_data}) *
                $signed({{64{source_b_data[63]}}, source_b_data}));
        end else begin
            prod = 128'({64'h0, source_a_data} *
                {64'h0, source_b_data});
        end
    end

    // exceptions: reserved wins over unusable
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rsvd_exc_ff <= 1'b0;
            unusable_exc_ff <= 1'b0;
            ovf_exc_ff <= 1'b0;
        end else if (clk_en) begin
            rsvd_exc_ff <= instr_valid && grp && !mode_ok;
            unusable_exc_ff <= instr_valid && mode_ok && !cop_ok &&
                (is_move_from || is_move_to);
            ovf_exc_ff <= 1'b0;
        end
    end

    // general register write: shifts and move-from
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gpr_we_ff <= 1'b0;
            gpr_idx_ff <= IDX_RST;
            gpr_data_ff <= WORD_RST;
        end else if (clk_en) begin
            gpr_we_ff <= 1'b0;
            if (go && is_shift) begin
                gpr_we_ff <= 1'b1;
                gpr_idx_ff <= rd_i;
                gpr_data_ff <= shift_res;
            end else if (go && is_move_from && cop_ok) begin
                // 32-bit targets pass whatever the read port gives
                gpr_we_ff <= 1'b1;
                gpr_idx_ff <= rt_i;
                gpr_data_ff <= sysctl_rd_data;
            end
        end
    end

    // product registers; hazard spacing is left to software
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prod_we_ff <= 1'b0;
            product_bottom_reg_ff <= WORD_RST;
            product_upper_reg_ff <= WORD_RST;
        end else if (clk_en) begin
            prod_we_ff <= go && is_mul;
            if (go && is_mul) begin
                product_bottom_reg_ff <= prod[63:0];
                product_upper_reg_ff <= prod[127:64];
            end
        end
    end

    // move-to: capture source at T, write at T+1 through a latch stage
    wsm_state_t mv_state_ff;
    logic [63:0] mv_data_ff;
    logic [4:0] mv_idx_ff;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mv_state_ff <= WSM_IDLE;
            mv_data_ff <= WORD_RST;
            mv_idx_ff <= IDX_RST;
        end else if (clk_en) begin
            case (mv_state_ff)
                WSM_IDLE: begin
                    if (go && is_move_to && cop_ok) begin
                        mv_state_ff <= WSM_MOVE;
                        mv_data_ff <= source_b_data;
                        mv_idx_ff <= rd_i;
                    end
                end
                WSM_MOVE: begin
                    if (go && is_move_to && cop_ok) begin
                        mv_data_ff <= source_b_data;
                        mv_idx_ff <= rd_i;
                    end else begin
                        mv_state_ff <= WSM_IDLE;
                    end
                end
                default: mv_state_ff <= WSM_IDLE;
            endcase
        end
    end

    // store may disturb translation; neighbours are software's concern
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sysctl_we_ff <= 1'b0;
            sysctl_idx_ff <= IDX_RST;
            sysctl_data_ff <= WORD_RST;
        end else if (clk_en) begin
            sysctl_we_ff <= (mv_state_ff == WSM_MOVE);
            sysctl_idx_ff <= mv_idx_ff;
            sysctl_data_ff <= mv_data_ff;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    reserved_mode_a: assert property (
        clk_en && instr_valid && grp && !mode_64bit && !mode_kernel
        |=> rsvd_exc_ff && !gpr_we_ff && !prod_we_ff)
        else $error("reserved mode instruction not trapped");
    unusable_move_a: assert property (
        clk_en && instr_valid && (is_move_from || is_move_to) && mode_ok &&
        !cop_ok |=> unusable_exc_ff && !gpr_we_ff)
        else $error("move without unit enabled not trapped");
    move_to_timing_a: assert property (
        go && is_move_to && cop_ok ##1 clk_en ##1 clk_en
        |-> sysctl_we_ff && sysctl_data_ff == $past(source_b_data, 2))
        else $error("move-to data not written two edges later");
    move_from_data_a: assert property (
        go && is_move_from && cop_ok
        |=> gpr_we_ff && gpr_data_ff == $past(sysctl_rd_data))
        else $error("move-from data wrong");
    product_split_a: assert property (
        go && is_mul && fn == FN_UMUL |=> prod_we_ff &&
        {product_upper_reg_ff, product_bottom_reg_ff} ==
        128'({64'h0, $past(source_a_data)} * {64'h0, $past(source_b_data)}))
        else $error("unsigned product wrong");
    no_overflow_a: assert property (!ovf_exc_ff)
        else $error("overflow raised by datapath");
    plus_shift_a: assert property (
        go && fn == FN_SLL32 && opc == OP_REGCLASS
        |=> gpr_data_ff[31:0] == 32'h00000000)
        else $error("plus-32 left shift leaves low bits set");
    arith_fill_a: assert property (
        go && fn == FN_SRA32 && opc == OP_REGCLASS && source_b_data[63]
        |=> gpr_data_ff[63:32] == 32'hFFFFFFFF)
        else $error("arithmetic fill missing");
    var_amount_a: assert property (
        go && fn == FN_SRLV && opc == OP_REGCLASS &&
        source_a_data[5:0] == 6'h00
        |=> gpr_data_ff == $past(source_b_data))
        else $error("variable shift uses high amount bits");
    signed_product_a: assert property (
        go && is_mul && fn == FN_SMUL |=> prod_we_ff &&
        $signed({product_upper_reg_ff, product_bottom_reg_ff}) ==
        $signed($past(source_a_data)) * $signed($past(source_b_data)))
        else $error("signed product wrong");
    logic_fill_a: assert property (
        go && opc == OP_REGCLASS && fn == FN_SRL && cnt != 5'h00
        |=> !gpr_data_ff[63])
        else $error("logical right shift fills with ones");

    mul_cover_c: cover property (go && is_mul);
    shift_cover_c: cover property (go && is_shift);
    move_to_cover_c: cover property (sysctl_we_ff);
    trap_cover_c: cover property (rsvd_exc_ff);
    unusable_cover_c: cover property (unusable_exc_ff);
endmodule : wsm_datapath

// *** wsm_sysctl_model.sv ***
// wsm_sysctl_model: decode-side model of the system-control register file.
// assumes the datapath reads the entry addressed by the dest field.
`timescale 1ns/1ps
module wsm_sysctl_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // instruction being presented
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    // write port from the datapath
    input wire logic sysctl_we_ff,
    input wire logic [4:0] sysctl_idx_ff,
    input wire logic [63:0] sysctl_data_ff,
    // read port
    output logic [63:0] sysctl_rd_data
);
    logic [63:0] regs_ff [32];
    logic [63:0] rd_word;

    assign rd_word = regs_ff[instr_word[15:11]];
    // idle read shows inverted data so a stale value never passes
    assign sysctl_rd_data = instr_valid ? rd_word : ~rd_word;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) begin
                regs_ff[i] <= 64'h0;
            end
        end else if (sysctl_we_ff) begin
            regs_ff[sysctl_idx_ff] <= sysctl_data_ff;
        end
    end
endmodule : wsm_sysctl_model

// *** wsm_datapath_bench.sv ***
// wsm_datapath_bench: self-checking bench for the wide datapath.
// assumes one instruction per cycle, inputs driven at the falling edge.
`timescale 1ns/1ps
module wsm_datapath_bench import wsm_pkg::*;;
    logic ref_clk, reset, clk_en, instr_valid;
    logic [31:0] instr_word;
    logic [63:0] source_a_data, source_b_data, sysctl_rd_data;
    logic mode_64bit, mode_kernel, sysctl_enabled;
    logic gpr_we_ff, prod_we_ff, sysctl_we_ff;
    logic rsvd_exc_ff, unusable_exc_ff, ovf_exc_ff;
    logic [4:0] gpr_idx_ff, sysctl_idx_ff;
    logic [63:0] gpr_data_ff, sysctl_data_ff;
    logic [63:0] product_bottom_reg_ff, product_upper_reg_ff;
    int errors, tests_run, cycles;

    wsm_datapath #(.WIDTH(64)) u_wsm_datapath (.ref_clk(ref_clk),
        .reset(reset), .clk_en(clk_en), .instr_valid(instr_valid),
        .instr_word(instr_word), .source_a_data(source_a_data),
        .source_b_data(source_b_data), .mode_64bit(mode_64bit),
        .mode_kernel(mode_kernel), .sysctl_enabled(sysctl_enabled),
        .sysctl_rd_data(sysctl_rd_data), .gpr_we_ff(gpr_we_ff),
        .gpr_idx_ff(gpr_idx_ff), .gpr_data_ff(gpr_data_ff),
        .prod_we_ff(prod_we_ff),
        .product_bottom_reg_ff(product_bottom_reg_ff),
        .product_upper_reg_ff(product_upper_reg_ff),
        .sysctl_we_ff(sysctl_we_ff), .sysctl_idx_ff(sysctl_idx_ff),
        .sysctl_data_ff(sysctl_data_ff), .rsvd_exc_ff(rsvd_exc_ff),
        .unusable_exc_ff(unusable_exc_ff), .ovf_exc_ff(ovf_exc_ff));

    wsm_sysctl_model u_wsm_sysctl_model (.ref_clk(ref_clk), .reset(reset),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .sysctl_we_ff(sysctl_we_ff), .sysctl_idx_ff(sysctl_idx_ff),
        .sysctl_data_ff(sysctl_data_ff), .sysctl_rd_data(sysctl_rd_data));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] enc(logic [5:0] op, logic [4:0] f1,
        logic [4:0] f2, logic [4:0] f3, logic [4:0] sa, logic [5:0] fn);
        return {op, f1, f2, f3, sa, fn};
    endfunction : enc

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic check_val(input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check_val

    // request held one full cycle; returns after the taking edge
    task automatic issue(input logic [31:0] w, input logic [63:0] a,
        input logic [63:0] b);
        instr_valid = 1'b1;
        instr_word = w;
        source_a_data = a;
        source_b_data = b;
        @(negedge ref_clk);
    endtask : issue

    task automatic idle();
        instr_valid = 1'b0;
        instr_word = 32'hFFFFFFFF;
        source_a_data = ~source_a_data;
        source_b_data = ~source_b_data;
        @(negedge ref_clk);
    endtask : idle

    task automatic test_shifts();
        logic [5:0] fns [8] = '{FN_SLL, FN_SRL, FN_SRA, FN_SLL32, FN_SRA32,
            FN_SLLV, FN_SRLV, FN_SRAV};
        logic [63:0] b, exp;
        logic [5:0] amt, f;
        logic [4:0] sa;
        logic vr;
        b = 64'h8421000000F0F00D;
        for (int i = 0; i < 16; i++) begin
            f = fns[i / 2];
            vr = (f == FN_SLLV || f == FN_SRLV || f == FN_SRAV);
            sa = i[0] ? 5'h1F : 5'h01;
            amt = vr ? (i[0] ? 6'h3F : 6'h05) :
                {f == FN_SLL32 || f == FN_SRA32, sa};
            if (f == FN_SLL || f == FN_SLL32 || f == FN_SLLV) exp = b << amt;
            else if (f == FN_SRL || f == FN_SRLV) exp = b >> amt;
            else exp = 64'($signed(b) >>> amt);
            // back-to-back, high bits of source_a set
            issue(enc(OP_REGCLASS, 5'h01, 5'h02, 5'(i), vr ? 5'h00 : sa, f),
                {58'h3FFFFFFFFFFFFFF, amt}, b);
            check_val(64'h1, {63'h0, gpr_we_ff});
            check_val(64'(i), {59'h0, gpr_idx_ff});
            check_val(exp, gpr_data_ff);
        end
        // zero low amount bits under set high bits must not shift
        issue(enc(OP_REGCLASS, 5'h01, 5'h02, 5'h1F, 5'h00, FN_SRLV),
            {58'h3FFFFFFFFFFFFFF, 6'h00}, b);
        check_val(b, gpr_data_ff);
        idle();
        $display("test shifts done");
    endtask : test_shifts

    task automatic test_mul();
        logic [63:0] av [3] = '{64'hFFFFFFFFFFFFFFFD, 64'hFFFFFFFFFFFFFFFF,
            64'h8000000000000000};
        logic [63:0] bv [3] = '{64'h5, 64'hFFFFFFFFFFFFFFFF,
            64'h8000000000000000};
        logic [127:0] p;
        // product registers are never read here, so no spacing is needed
        for (int i = 0; i < 6; i++) begin
            if (i[0]) p = {64'h0, av[i / 2]} * {64'h0, bv[i / 2]};
            else p = $signed({{64{av[i / 2][63]}}, av[i / 2]}) *
                $signed({{64{bv[i / 2][63]}}, bv[i / 2]});
            issue(enc(OP_REGCLASS, 5'h01, 5'h02, 5'h00, 5'h00,
                i[0] ? FN_UMUL : FN_SMUL), av[i / 2], bv[i / 2]);
            check_val(64'h1, {63'h0, prod_we_ff});
            check_val(p[63:0], product_bottom_reg_ff);
            check_val(p[127:64], product_upper_reg_ff);
            check_val(64'h0, {63'h0, ovf_exc_ff});
        end
        idle();
        $display("test multiply done");
    endtask : test_mul

    task automatic test_moves();
        issue(enc(OP_SYSCTL, SUB_MTW, 5'h07, 5'h05, 5'h00, 6'h00), 64'h0,
            64'hA5A5000011112222);
        issue(enc(OP_SYSCTL, SUB_MTW, 5'h08, 5'h09, 5'h00, 6'h00), 64'h0,
            64'h0123456789ABCDEF);
        check_val(64'h1, {63'h0, sysctl_we_ff});
        check_val(64'h5, {59'h0, sysctl_idx_ff});
        check_val(64'hA5A5000011112222, sysctl_data_ff);
        idle();
        check_val(64'h9, {59'h0, sysctl_idx_ff});
        check_val(64'h0123456789ABCDEF, sysctl_data_ff);
        idle();
        issue(enc(OP_SYSCTL, SUB_MFW, 5'h04, 5'h09, 5'h00, 6'h00), 64'h0,
            64'h0);
        check_val(64'h1, {63'h0, gpr_we_ff});
        check_val(64'h4, {59'h0, gpr_idx_ff});
        check_val(64'h0123456789ABCDEF, gpr_data_ff);
        idle();
        $display("test moves done");
    endtask : test_moves

    task automatic test_modes();
        mode_64bit = 1'b0;
        mode_kernel = 1'b0;
        issue(enc(OP_REGCLASS, 5'h00, 5'h02, 5'h03, 5'h04, FN_SLL), 64'h0,
            64'h1);
        check_val(64'h1, {63'h0, rsvd_exc_ff});
        check_val(64'h0, {63'h0, gpr_we_ff});
        issue(enc(OP_REGCLASS, 5'h01, 5'h02, 5'h00, 5'h00, FN_SMUL), 64'h3,
            64'h3);
        check_val(64'h0, {63'h0, prod_we_ff});
        mode_64bit = 1'b1;
        sysctl_enabled = 1'b0;
        issue(enc(OP_SYSCTL, SUB_MTW, 5'h07, 5'h05, 5'h00, 6'h00), 64'h0,
            64'h7);
        check_val(64'h1, {63'h0, unusable_exc_ff});
        issue(enc(OP_SYSCTL, SUB_MFW, 5'h04, 5'h09, 5'h00, 6'h00), 64'h0,
            64'h0);
        check_val(64'h1, {63'h0, unusable_exc_ff});
        check_val(64'h0, {63'h0, gpr_we_ff});
        idle();
        check_val(64'h0, {63'h0, sysctl_we_ff});
        mode_64bit = 1'b0;
        mode_kernel = 1'b1;
        issue(enc(OP_REGCLASS, 5'h00, 5'h02, 5'h03, 5'h04, FN_SLL), 64'h0,
            64'h1);
        check_val(64'h10, gpr_data_ff);
        // kernel reaches the unit even while it is disabled
        issue(enc(OP_SYSCTL, SUB_MFW, 5'h04, 5'h09, 5'h00, 6'h00), 64'h0,
            64'h0);
        check_val(64'h0, {63'h0, unusable_exc_ff});
        check_val(64'h0123456789ABCDEF, gpr_data_ff);
        idle();
        mode_64bit = 1'b1;
        sysctl_enabled = 1'b1;
        $display("test modes done");
    endtask : test_modes

    // clock enable low must hold a standing pulse; reset mid-run clears
    task automatic test_freeze();
        issue(enc(OP_REGCLASS, 5'h00, 5'h02, 5'h06, 5'h08, FN_SLL), 64'h0,
            64'h3);
        clk_en = 1'b0;
        issue(enc(OP_REGCLASS, 5'h00, 5'h02, 5'h07, 5'h01, FN_SRL), 64'h0,
            64'h1);
        check_val(64'h1, {63'h0, gpr_we_ff});
        check_val(64'h6, {59'h0, gpr_idx_ff});
        check_val(64'h300, gpr_data_ff);
        clk_en = 1'b1;
        idle();
        check_val(64'h0, {63'h0, gpr_we_ff});
        reset = 1'b1;
        idle();
        check_val(64'h0, gpr_data_ff);
        reset = 1'b0;
        issue(enc(OP_REGCLASS, 5'h00, 5'h02, 5'h05, 5'h01, FN_SLL), 64'h0,
            64'h5);
        check_val(64'hA, gpr_data_ff);
        idle();
        $display("test freeze done");
    endtask : test_freeze

    // runaway guard, far above the roughly 60 cycles needed
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        errors = 0;
        tests_run = 0;
        cycles = 0;
        reset = 1'b1;
        clk_en = 1'b1;
        instr_valid = 1'b0;
        instr_word = 32'hFFFFFFFF;
        source_a_data = 64'h0;
        source_b_data = 64'h0;
        mode_64bit = 1'b1;
        mode_kernel = 1'b1;
        sysctl_enabled = 1'b1;
        repeat (16) @(negedge ref_clk);
        reset = 1'b0;
        test_shifts();
        test_mul();
        test_moves();
        test_modes();
        test_freeze();
        print_verdict();
    end
endmodule : wsm_datapath_bench
